// ===== hdl/oad_decode.sv
// module: operand address decoder, fed one instruction byte per cycle
// How it works
// - reg field picks word, byte or segment
// - mode 00 means zero displacement
// - mode 01 sign-extends one displacement byte
// - mode 10 takes low byte then high
// - displacement follows second byte, before data
// - mode 00 r/m 110 is direct address
// - code and stack accesses ignore overrides
// - frame pointer defaults stack, override allowed
// - index operands without the frame pointer default data, override allowed
// - string source defaults data, override allowed
// - string destination always extra segment
// - flag word bit layout fixed
// - trap flag requests single-step trap
// - aux carry holds low digit carry
module oad_decode (
    input wire logic clk,
    input wire logic rstn,
    input wire logic modrm_valid,
    input wire logic [7:0] modrm_byte,
    input wire logic word_width,
    input wire logic byte_valid,
    input wire logic [7:0] fetch_byte,
    input wire oad_pkg::oad_regs_type regs,
    input wire oad_pkg::oad_override_type override,
    input wire oad_pkg::oad_access_type access_kind,
    input wire logic [1:0] seg_field,
    input wire oad_pkg::oad_flags_type flags_in,
    input wire logic instr_end,
    output oad_pkg::oad_result_type result,
    output logic result_valid,
    output logic disp_busy,
    output logic [1:0] seg_field_sel,
    output logic [1:0] access_seg,
    output logic [15:0] flag_word,
    output logic step_trap
);

    // idle waits for a second byte; low and high collect the displacement
    typedef enum logic [1:0] {st_idle, st_low, st_high} oad_state_type;

    // fields of the second byte, kept while the displacement bytes arrive
    oad_state_type state;
    logic [1:0] mode;
    logic [2:0] rm;
    logic direct;
    logic [7:0] disp_low;

    ////////////////////////////////////////////////////////////////////
    // read a register by the 3-bit select and width
    // byte selects return the chosen half zero-extended
    function automatic logic [15:0] read_reg(input logic [2:0] sel, input logic w,
                                             input oad_pkg::oad_regs_type r);
        logic [15:0] v;
        v = 16'h0000;
        if (w) begin
            case (sel)
                3'h0: v = r.accumulator_word;
                3'h1: v = r.count_word;
                3'h2: v = r.data_word;
                3'h3: v = r.base_word;
                3'h4: v = r.stack_pointer;
                3'h5: v = r.frame_pointer;
                3'h6: v = r.source_index;
                default: v = r.destination_index;
            endcase
        end else begin // low bytes of the first four, then their high bytes
            case (sel)
                3'h0: v = {8'h00, r.accumulator_word[7:0]};
                3'h1: v = {8'h00, r.count_word[7:0]};
                3'h2: v = {8'h00, r.data_word[7:0]};
                3'h3: v = {8'h00, r.base_word[7:0]};
                3'h4: v = {8'h00, r.accumulator_word[15:8]};
                3'h5: v = {8'h00, r.count_word[15:8]};
                3'h6: v = {8'h00, r.data_word[15:8]};
                default: v = {8'h00, r.base_word[15:8]};
            endcase
        end
        return v;
    endfunction

    // base combination for memory modes
    // sums wrap at 16 bits, the same as the address adder
    function automatic logic [15:0] ea_base(input logic [2:0] sel, input oad_pkg::oad_regs_type r);
        logic [15:0] b;
        b = 16'h0000;
        case (sel)
            3'h0: b = r.base_word + r.source_index;
            3'h1: b = r.base_word + r.destination_index;
            3'h2: b = r.frame_pointer + r.source_index;
            3'h3: b = r.frame_pointer + r.destination_index;
            3'h4: b = r.source_index;
            3'h5: b = r.destination_index;
            3'h6: b = r.frame_pointer;
            default: b = r.base_word;
        endcase
        return b;
    endfunction

    // default segment, with override where permitted
    // code, stack and string destination ignore any prefix
    // an operand override may name any segment, data included
    function automatic logic [1:0] pick_seg(input oad_pkg::oad_access_type k,
                                            input logic uses_frame,
                                            input oad_pkg::oad_override_type ov);
        logic [1:0] s;
        s = oad_pkg::seg_data;
        case (k)
            oad_pkg::acc_code: s = oad_pkg::seg_code;
            oad_pkg::acc_stack: s = oad_pkg::seg_stack;
            oad_pkg::acc_str_dst: s = oad_pkg::seg_extra;
            oad_pkg::acc_str_src: s = ov.valid ? ov.seg : oad_pkg::seg_data;
            default: begin
                if (uses_frame) begin
                    s = ov.valid ? ov.seg : oad_pkg::seg_stack;
                end else begin
                    s = ov.valid ? ov.seg : oad_pkg::seg_data;
                end
            end
        endcase
        return s;
    endfunction

    // memory operand uses the frame pointer (not for the direct address)
    // a direct address has no base register, so it falls back to data
    function automatic logic frame_based(input logic [1:0] md, input logic [2:0] sel);
        return (sel == 3'h2) || (sel == 3'h3) ||
               ((sel == oad_pkg::rm_direct) && (md != oad_pkg::mode_nodisp));
    endfunction

    // second byte asks for the direct-address form
    function automatic logic is_direct(input logic [1:0] md, input logic [2:0] sel);
        return (md == oad_pkg::mode_nodisp) && (sel == oad_pkg::rm_direct);
    endfunction

    // second byte is followed by displacement or direct-address bytes
    function automatic logic needs_bytes(input logic [1:0] md, input logic [2:0] sel);
        return (md == oad_pkg::mode_disp8) || (md == oad_pkg::mode_disp16) ||
               is_direct(md, sel);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // displacement byte sequencer; bytes right after the second byte are displacement
    // a second byte that arrives while bytes are owed is ignored, not queued
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= st_idle;
            mode <= 2'h0;
            rm <= 3'h0;
            direct <= 1'b0;
            disp_low <= 8'h00;
        end else begin
            case (state)
                st_idle: begin
                    // regs are not read here; they are read when the last byte lands
                    if (modrm_valid) begin
                        mode <= modrm_byte[7:6];
                        rm <= modrm_byte[2:0];
                        direct <= is_direct(modrm_byte[7:6], modrm_byte[2:0]);
                        if (needs_bytes(modrm_byte[7:6], modrm_byte[2:0])) begin
                            state <= st_low;
                        end
                    end
                end
                st_low: begin
                    // the first byte after the second byte is always the low half
                    if (byte_valid) begin
                        disp_low <= fetch_byte;
                        state <= (mode == oad_pkg::mode_disp8) ? st_idle : st_high;
                    end
                end
                st_high: begin
                    // the high half is used straight off the bus, never stored
                    if (byte_valid) begin
                        state <= st_idle;
                    end
                end
                default: state <= st_idle;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // result register; produced when the last operand-address byte arrives
    // override and regs are sampled at the final byte and must hold until then
    always_ff @(posedge clk) begin
        if (!rstn) begin
            result <= '0;
            result_valid <= 1'b0;
        end else begin
            // pulse for one cycle; the result itself holds until the next one
            result_valid <= 1'b0;
            if (state == st_idle && modrm_valid) begin
                // register operand: no memory access, segment field unused
                if (modrm_byte[7:6] == oad_pkg::mode_reg) begin
                    result.is_reg <= 1'b1;
                    result.reg_sel <= modrm_byte[2:0];
                    result.reg_value <= read_reg(modrm_byte[2:0], word_width, regs);
                    result.effective_addr <= 16'h0000;
                    result.seg <= oad_pkg::reset_seg;
                    result_valid <= 1'b1;
                end else if (!needs_bytes(modrm_byte[7:6], modrm_byte[2:0])) begin
                    // memory operand with no bytes owed: result right away
                    result.is_reg <= 1'b0; // zero displacement
                    result.reg_sel <= modrm_byte[2:0];
                    result.reg_value <= 16'h0000;
                    result.effective_addr <= ea_base(modrm_byte[2:0], regs);
                    result.seg <= pick_seg(oad_pkg::acc_operand,
                                           frame_based(modrm_byte[7:6], modrm_byte[2:0]),
                                           override);
                    result_valid <= 1'b1;
                end
            end else if (state == st_low && byte_valid && mode == oad_pkg::mode_disp8) begin
                // short displacement: result on its single byte
                result.is_reg <= 1'b0;
                result.reg_sel <= rm;
                result.reg_value <= 16'h0000;
                result.effective_addr <= ea_base(rm, regs) +
                                         {{8{fetch_byte[7]}}, fetch_byte};
                result.seg <= pick_seg(oad_pkg::acc_operand, frame_based(mode, rm), override);
                result_valid <= 1'b1;
            end else if (state == st_high && byte_valid) begin
                // long displacement or direct address: result on the high byte
                result.is_reg <= 1'b0;
                result.reg_sel <= rm;
                result.reg_value <= 16'h0000;
                if (direct) begin
                    result.effective_addr <= {fetch_byte, disp_low};
                end else begin
                    result.effective_addr <= ea_base(rm, regs) +
                                             {fetch_byte, disp_low};
                end
                result.seg <= pick_seg(oad_pkg::acc_operand, frame_based(mode, rm), override);
                result_valid <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // busy while displacement bytes are still owed; immediates must wait
    // it mirrors state != idle, kept as its own flop so the port is registered
    always_ff @(posedge clk) begin
        if (!rstn) begin
            disp_busy <= 1'b0;
        end else begin
            case (state)
                st_idle: disp_busy <= modrm_valid &&
                        needs_bytes(modrm_byte[7:6], modrm_byte[2:0]);
                st_low: disp_busy <= !(byte_valid && mode == oad_pkg::mode_disp8);
                st_high: disp_busy <= !byte_valid;
                default: disp_busy <= 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // segment register select and implicit access segment
    // frame-based defaults are not applied here; the operand path has its own
    // seg_field_sel only delays the field, it does not decode it
    always_ff @(posedge clk) begin
        if (!rstn) begin
            seg_field_sel <= oad_pkg::reset_seg;
            access_seg <= oad_pkg::reset_seg;
        end else begin
            seg_field_sel <= seg_field; // 00 extra, 01 code, 10 stack, 11 data
            access_seg <= pick_seg(access_kind, 1'b0, override);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // flag word assembly; unused bits are driven zero
    // don't-care positions read zero so the word compares cleanly
    always_ff @(posedge clk) begin
        if (!rstn) begin
            flag_word <= oad_pkg::reset_word;
        end else begin
            flag_word <= oad_pkg::reset_word;
            // arithmetic flags sit in the low byte
            flag_word[oad_pkg::flag_carry_pos] <= flags_in.carry_flag;
            flag_word[oad_pkg::flag_parity_pos] <= flags_in.parity_flag;
            flag_word[oad_pkg::flag_aux_pos] <= flags_in.aux_carry_flag;
            flag_word[oad_pkg::flag_zero_pos] <= flags_in.zero_flag;
            flag_word[oad_pkg::flag_sign_pos] <= flags_in.sign_flag;
            // control flags and overflow sit in the high byte
            flag_word[oad_pkg::flag_trap_pos] <= flags_in.trap_flag;
            flag_word[oad_pkg::flag_int_pos] <= flags_in.int_flag;
            flag_word[oad_pkg::flag_dir_pos] <= flags_in.direction_flag;
            flag_word[oad_pkg::flag_ovf_pos] <= flags_in.overflow_flag;
        end
    end

    // single-step: trap pulse after each completed instruction
    // the trap flag is taken with the end pulse, so a flag set mid-instruction waits
    always_ff @(posedge clk) begin
        if (!rstn) begin
            step_trap <= 1'b0;
        end else begin
            step_trap <= instr_end && flags_in.trap_flag;
        end
    end

endmodule // oad_decode

// ===== hdl/oad_pkg.sv
// package: encodings, field positions and reset values for the operand address decoder
package oad_pkg;

    // segment register encodings of the 2-bit segment field
    localparam logic [1:0] seg_extra = 2'h0;
    localparam logic [1:0] seg_code = 2'h1;
    localparam logic [1:0] seg_stack = 2'h2;
    localparam logic [1:0] seg_data = 2'h3;

    // addressing-mode field values
    localparam logic [1:0] mode_nodisp = 2'h0;
    localparam logic [1:0] mode_disp8 = 2'h1;
    localparam logic [1:0] mode_disp16 = 2'h2;
    localparam logic [1:0] mode_reg = 2'h3;
    localparam logic [2:0] rm_direct = 3'h6;

    // flag word bit positions
    localparam int flag_carry_pos = 0;
    localparam int flag_parity_pos = 2;
    localparam int flag_aux_pos = 4;
    localparam int flag_zero_pos = 6;
    localparam int flag_sign_pos = 7;
    localparam int flag_trap_pos = 8;
    localparam int flag_int_pos = 9;
    localparam int flag_dir_pos = 10;
    localparam int flag_ovf_pos = 11;

    // reset values
    localparam logic [15:0] reset_word = 16'h0000;
    localparam logic [1:0] reset_seg = 2'h3;

    // kind of memory access asked for
    typedef enum logic [2:0] {
        acc_operand,
        acc_code,
        acc_stack,
        acc_str_src,
        acc_str_dst
    } oad_access_type;

    // register file snapshot presented by the core
    typedef struct packed {
        logic [15:0] accumulator_word;
        logic [15:0] count_word;
        logic [15:0] data_word;
        logic [15:0] base_word;
        logic [15:0] stack_pointer;
        logic [15:0] frame_pointer;
        logic [15:0] source_index;
        logic [15:0] destination_index;
    } oad_regs_type;

    // segment override prefix
    typedef struct packed {
        logic valid;
        logic [1:0] seg;
    } oad_override_type;

    // decoded operand result
    typedef struct packed {
        logic is_reg;
        logic [2:0] reg_sel;
        logic [15:0] reg_value;
        logic [15:0] effective_addr;
        logic [1:0] seg;
    } oad_result_type;

    // flag inputs from the arithmetic unit
    typedef struct packed {
        logic carry_flag;
        logic parity_flag;
        logic aux_carry_flag;
        logic zero_flag;
        logic sign_flag;
        logic trap_flag;
        logic int_flag;
        logic direction_flag;
        logic overflow_flag;
    } oad_flags_type;

endpackage

// ===== verif/oad_decode_bench.sv
// bench: self-checking testbench for the operand address decoder
module oad_decode_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rstn, modrm_valid, word_width, byte_valid, instr_end;
    logic result_valid, disp_busy, step_trap;
    logic [7:0] modrm_byte, fetch_byte;
    logic [1:0] seg_field, seg_field_sel, access_seg;
    logic [15:0] flag_word;
    logic [15:0] r [8];
    oad_pkg::oad_override_type override;
    oad_pkg::oad_access_type access_kind;
    oad_pkg::oad_flags_type flags_in;
    oad_pkg::oad_result_type result;
    int n_mismatch, checks;
    oad_pkg::oad_regs_type regs_w;
    // register snapshot packed in field order, accumulator first
    assign regs_w = {r[0], r[1], r[2], r[3], r[4], r[5], r[6], r[7]};
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    oad_fetch_model u_oad_fetch_model (.clk(clk), .byte_valid(byte_valid),
        .fetch_byte(fetch_byte));
    oad_decode u_oad_decode (.clk(clk), .rstn(rstn), .modrm_valid(modrm_valid),
        .modrm_byte(modrm_byte), .word_width(word_width), .byte_valid(byte_valid),
        .fetch_byte(fetch_byte), .regs(regs_w),
        .override(override), .access_kind(access_kind), .seg_field(seg_field),
        .flags_in(flags_in), .instr_end(instr_end), .result(result),
        .result_valid(result_valid), .disp_busy(disp_busy), .seg_field_sel(seg_field_sel),
        .access_seg(access_seg), .flag_word(flag_word), .step_trap(step_trap));
    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk_res(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR result t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_sig(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR side t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one operand decode; a stalled stream also gets a stray second byte that must be ignored
    task automatic run_op(input logic [1:0] md, input logic [2:0] rm, input int gap);
        logic [7:0] b0, b1;
        logic [15:0] disp, ea, rv;
        logic [1:0] sg;
        int n, t;
        b0 = 8'($urandom);
        b1 = 8'($urandom);
        foreach (r[i]) r[i] = 16'($urandom);
        override = 3'($urandom);
        word_width = 1'($urandom);
        n = (md == 2'h1) ? 1 : (md == 2'h2 || (md == 2'h0 && rm == 3'h6)) ? 2 : 0;
        modrm_byte = {md, 3'($urandom), rm};
        modrm_valid = 1'b1;
        @(negedge clk);
        modrm_valid = 1'b0;
        fork
            u_oad_fetch_model.send(b0, b1, n, gap);
            if (gap > 0 && n > 0) begin
                @(negedge clk);
                modrm_valid = 1'b1;
                modrm_byte = 8'hc0;
                @(negedge clk);
                modrm_valid = 1'b0;
            end
        join
        t = 0;
        while (result_valid !== 1'b1 && t < 8) begin
            @(negedge clk);
            t++;
        end
        if (result_valid !== 1'b1) begin
            n_mismatch++;
            test_done();
        end
        disp = (md == 2'h1) ? {{8{b0[7]}}, b0} : (n == 2) ? {b1, b0} : 16'h0000;
        case (rm)
            3'h0: ea = r[3] + r[6];
            3'h1: ea = r[3] + r[7];
            3'h2: ea = r[5] + r[6];
            3'h3: ea = r[5] + r[7];
            3'h4: ea = r[6];
            3'h5: ea = r[7];
            3'h6: ea = (md == 2'h0) ? 16'h0000 : r[5];
            default: ea = r[3];
        endcase
        sg = (rm == 3'h2 || rm == 3'h3 || (rm == 3'h6 && md != 2'h0)) ? 2'h2 : 2'h3;
        if (override.valid) sg = override.seg;
        rv = word_width ? r[rm] : rm[2] ? {8'h00, r[rm[1:0]][15:8]} : {8'h00, r[rm[1:0]][7:0]};
        chk_res(16'(result.is_reg), 16'(md == 2'h3));
        if (md == 2'h3) begin
            chk_res(16'(result.reg_sel), 16'(rm));
            chk_res(result.reg_value, rv);
            chk_res(16'(result.seg), 16'h0003);
        end else begin
            chk_res(result.effective_addr, ea + disp);
            chk_res(16'(result.seg), 16'(sg));
        end
        chk_res(16'(disp_busy), 16'h0000);
        @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // reset, then every mode and r/m prompt and stalled, then implicit segments and flags
    initial begin
        rstn = 1'b0;
        modrm_valid = 1'b0;
        modrm_byte = 8'h00;
        word_width = 1'b0;
        instr_end = 1'b0;
        seg_field = 2'h0;
        override = '0;
        access_kind = oad_pkg::acc_operand;
        flags_in = '0;
        n_mismatch = 0;
        checks = 0;
        foreach (r[i]) r[i] = 16'h0000;
        void'($urandom(38));
        repeat (5) @(negedge clk);
        chk_sig({12'h000, access_seg, seg_field_sel}, 16'h000f);
        chk_sig({flag_word[15:1], result_valid}, 16'h0000);
        rstn = 1'b1;
        for (int k = 0; k < 96; k++)
            run_op(2'(k % 4), 3'(k / 4), (k < 32) ? 0 : 2 + int'($urandom % 2));
        for (int k = 0; k < 40; k++) begin
            access_kind = oad_pkg::oad_access_type'(k % 5);
            override = 3'($urandom);
            seg_field = 2'($urandom);
            flags_in = 9'($urandom);
            instr_end = 1'($urandom);
            @(negedge clk);
            case (k % 5)
                1: chk_sig(16'(access_seg), 16'h0001);
                2: chk_sig(16'(access_seg), 16'h0002);
                4: chk_sig(16'(access_seg), 16'h0000);
                default: chk_sig(16'(access_seg), override.valid ? 16'(override.seg) : 16'h3);
            endcase
            chk_sig(16'(seg_field_sel), 16'(seg_field));
            chk_sig(flag_word, {4'h0, flags_in.overflow_flag, flags_in.direction_flag,
                flags_in.int_flag, flags_in.trap_flag, flags_in.sign_flag, flags_in.zero_flag,
                1'b0, flags_in.aux_carry_flag, 1'b0, flags_in.parity_flag, 1'b0,
                flags_in.carry_flag});
            chk_sig(16'(step_trap), 16'(instr_end & flags_in.trap_flag));
        end
        test_done();
    end
endmodule // oad_decode_bench

// ===== verif/oad_decode_monitor.sv
// checker: timing and encoding relations on the decoder ports
module oad_decode_monitor (
    input wire logic clk,
    input wire logic rstn,
    input wire logic modrm_valid,
    input wire logic [7:0] modrm_byte,
    input wire logic word_width,
    input wire logic byte_valid,
    input wire logic [7:0] fetch_byte,
    input wire oad_pkg::oad_regs_type regs,
    input wire oad_pkg::oad_override_type override,
    input wire oad_pkg::oad_access_type access_kind,
    input wire logic [1:0] seg_field,
    input wire oad_pkg::oad_flags_type flags_in,
    input wire logic instr_end,
    input wire oad_pkg::oad_result_type result,
    input wire logic result_valid,
    input wire logic disp_busy,
    input wire logic [1:0] seg_field_sel,
    input wire logic [1:0] access_seg,
    input wire logic [15:0] flag_word,
    input wire logic step_trap
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    logic take;
    // a second byte while bytes are owed is ignored, so gate on idle
    assign take = modrm_valid && !disp_busy;
    ////////////////////////////////////////////////////////////////////////
    property p_flags;
        $past(rstn) |-> flag_word[15:12] == 4'h0 && flag_word[0] == $past(flags_in.carry_flag)
            && flag_word[8] == $past(flags_in.trap_flag);
    endproperty
    a_flags: assert property (p_flags) else $error("flag word layout wrong");
    property p_trap;
        $past(rstn) |-> step_trap == ($past(instr_end) && $past(flags_in.trap_flag));
    endproperty
    a_trap: assert property (p_trap) else $error("single-step trap wrong");
    property p_segf;
        $past(rstn) |-> seg_field_sel == $past(seg_field);
    endproperty
    a_segf: assert property (p_segf) else $error("segment field select wrong");
    property p_code;
        $past(rstn) && $past(access_kind) == oad_pkg::acc_code |-> access_seg == oad_pkg::seg_code;
    endproperty
    a_code: assert property (p_code) else $error("code fetch segment wrong");
    property p_sdst;
        $past(rstn) && $past(access_kind) == oad_pkg::acc_str_dst
            |-> access_seg == oad_pkg::seg_extra;
    endproperty
    a_sdst: assert property (p_sdst) else $error("string destination segment wrong");
    property p_ssrc;
        $past(rstn) && $past(access_kind) == oad_pkg::acc_str_src
            |-> access_seg == ($past(override.valid) ? $past(override.seg) : oad_pkg::seg_data);
    endproperty
    a_ssrc: assert property (p_ssrc) else $error("string source segment wrong");
    property p_d8;
        take && modrm_byte[7:6] == oad_pkg::mode_disp8 |=> disp_busy && !result_valid;
    endproperty
    a_d8: assert property (p_d8) else $error("short displacement not awaited");
    property p_d16;
        take && modrm_byte[7:6] == oad_pkg::mode_disp16 |=> disp_busy [*2];
    endproperty
    a_d16: assert property (p_d16) else $error("long displacement not awaited");
    property p_dir;
        take && modrm_byte[7:6] == oad_pkg::mode_nodisp && modrm_byte[2:0] == oad_pkg::rm_direct
            |=> disp_busy [*2];
    endproperty
    a_dir: assert property (p_dir) else $error("direct address not awaited");
    property p_nod;
        take && modrm_byte[7:6] == oad_pkg::mode_nodisp && modrm_byte[2:0] != oad_pkg::rm_direct
            |=> result_valid && !disp_busy && !result.is_reg;
    endproperty
    a_nod: assert property (p_nod) else $error("zero displacement result late");
    property p_reg;
        take && modrm_byte[7:6] == oad_pkg::mode_reg |=> result_valid && result.is_reg;
    endproperty
    a_reg: assert property (p_reg) else $error("register operand result wrong");
endmodule // oad_decode_monitor

bind oad_decode oad_decode_monitor u_oad_decode_monitor (.clk(clk), .rstn(rstn),
    .modrm_valid(modrm_valid), .modrm_byte(modrm_byte), .word_width(word_width),
    .byte_valid(byte_valid), .fetch_byte(fetch_byte), .regs(regs), .override(override),
    .access_kind(access_kind), .seg_field(seg_field), .flags_in(flags_in),
    .instr_end(instr_end), .result(result), .result_valid(result_valid),
    .disp_busy(disp_busy), .seg_field_sel(seg_field_sel), .access_seg(access_seg),
    .flag_word(flag_word), .step_trap(step_trap));

// ===== verif/oad_fetch_model.sv
// partner: fetch stream that hands displacement bytes to the decoder
module oad_fetch_model (
    input wire logic clk,
    output logic byte_valid,
    output logic [7:0] fetch_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] held;
    logic [7:0] junk;
    initial begin
        byte_valid = 1'b0;
        held = 8'h00;
        junk = 8'h5a;
    end
    // idle bus shows a changing pattern, never the last byte
    always @(negedge clk) junk <= junk + 8'h3b;
    assign fetch_byte = byte_valid ? held : ~junk;
    ////////////////////////////////////////////////////////////////////////
    // low byte first, right after the second byte; gap stalls each byte
    task automatic send(input logic [7:0] b0, input logic [7:0] b1, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            if (gap > 0) begin
                byte_valid = 1'b0;
                repeat (gap) @(negedge clk);
            end
            held = (i == 0) ? b0 : b1;
            byte_valid = 1'b1;
            @(negedge clk);
        end
        byte_valid = 1'b0;
    endtask
endmodule // oad_fetch_model
